// *** design/dtec_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module dtec_top
  import dtec_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // external count inputs
  input  wire logic        ctr0_event_in,
  input  wire logic        ctr1_event_in,
  // interrupt requests and wake
  output logic             ctr0_irq,
  output logic             ctr1_irq,
  output logic             wake,
  // pin and clock outputs
  output logic             porta_pin3,
  output logic             freq_divider_out,
  output logic             pwm_clk_tick
);
  import dtec_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    return adr[7:2] == idx;
  endfunction : hit

  function automatic logic psc_tick(input logic [PSC_W-1:0] p, input logic [2:0] c);
    logic [PSC_W-1:0] m;
    logic [2:0]       k;
    k = (c == 3'h0) ? 3'h1 : c;
    m = PSC_W'((8'h01 << k) - 8'h01);
    return (p & m) == m;
  endfunction : psc_tick

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic             ack_r;
  logic [31:0]      dat_r;
  logic [7:0]       ctrl0_r;
  logic [7:0]       ctrl1_r;
  logic [PSC_W-1:0] psc_r;
  logic             flag0_r, flag1_r;
  logic             ien0_r, ien1_r;
  logic             div_on_r, div_src_r;
  logic             pin3_latch_r;
  logic             div_q_r;
  logic             irq0_r, irq1_r, wake_r, pin_r, pwm_r;
  logic [15:0]      count0, count1;
  logic             run0, run1;
  logic             ovf0, ovf1;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // ack comes one cycle after the request; writes land on the ack edge
  wire req       = wb_cyc_i & wb_stb_i;
  wire wr        = req & wb_we_i & ack_r;
  wire rd        = req & ~wb_we_i;
  wire hit_ctrl0 = hit(wb_adr_i, CTRL0_IDX);
  wire hit_ctrl1 = hit(wb_adr_i, CTRL1_IDX);
  wire hit_cnt0  = hit(wb_adr_i, CNT0_IDX);
  wire hit_cnt1  = hit(wb_adr_i, CNT1_IDX);
  wire hit_misc  = hit(wb_adr_i, MISC_IDX);
  wire wr_ctrl0  = wr & hit_ctrl0 & wb_sel_i[0];
  wire wr_ctrl1  = wr & hit_ctrl1 & wb_sel_i[0];
  wire wr_misc   = wr & hit_misc & wb_sel_i[0];
  wire [1:0] be0 = (wr & hit_cnt0) ? wb_sel_i[1:0] : 2'b00;
  wire [1:0] be1 = (wr & hit_cnt1) ? wb_sel_i[1:0] : 2'b00;
  // read holds the count for the whole cycle, at the cost of lost ticks
  wire hold0     = rd & hit_cnt0;
  wire hold1     = rd & hit_cnt1;

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  wire [7:0] ctrl0_view = {ctrl0_r[7:6], 1'b0, run0, ctrl0_r[3:0]};
  wire [7:0] ctrl1_view = {ctrl1_r[7:6], 1'b0, run1, ctrl1_r[3], 3'b000};
  wire [7:0] misc_view  = {div_q_r, pin3_latch_r, div_src_r, div_on_r,
                           ien1_r, ien0_r, flag1_r, flag0_r};
  wire [31:0] rd_word   = hit_ctrl0 ? {24'h00_0000, ctrl0_view} :
                          hit_ctrl1 ? {24'h00_0000, ctrl1_view} :
                          hit_cnt0  ? {16'h0000, count0} :
                          hit_cnt1  ? {16'h0000, count1} :
                          hit_misc  ? {24'h00_0000, misc_view} :
                          32'h0000_0000;

  wire dtec_mode_t mode0 = dtec_mode_t'(ctrl0_r[CTL_MODE_LSB +: 2]);
  wire dtec_mode_t mode1 = dtec_mode_t'(ctrl1_r[CTL_MODE_LSB +: 2]);

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  wire tick0 = psc_tick(psc_r, ctrl0_r[CTL_PSC_LSB +: 3]);
  // counter 1 has no prescaler and runs on the system clock
  wire tick1 = 1'b1;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  dtec_counter u_ctr0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .ev_in     (ctr0_event_in),
    .tick      (tick0),
    .mode      (mode0),
    .edge_sel  (ctrl0_r[CTL_EDGE_BIT]),
    .hold      (hold0),
    .pre_be    (be0),
    .pre_wdata (wb_dat_i[15:0]),
    .run_wr    (wr_ctrl0),
    .run_wdata (wb_dat_i[CTL_RUN_BIT]),
    .count     (count0),
    .run       (run0),
    .ovf       (ovf0)
  );

  dtec_counter u_ctr1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .ev_in     (ctr1_event_in),
    .tick      (tick1),
    .mode      (mode1),
    .edge_sel  (ctrl1_r[CTL_EDGE_BIT]),
    .hold      (hold1),
    .pre_be    (be1),
    .pre_wdata (wb_dat_i[15:0]),
    .run_wr    (wr_ctrl1),
    .run_wdata (wb_dat_i[CTL_RUN_BIT]),
    .count     (count1),
    .run       (run1),
    .ovf       (ovf1)
  );

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  wire [7:0] ctrl0_nxt = wr_ctrl0 ? (wb_dat_i[7:0] & 8'hCF) : ctrl0_r;
  wire [7:0] ctrl1_nxt = wr_ctrl1 ? (wb_dat_i[7:0] & 8'hC8) : ctrl1_r;
  // writing zero clears a flag; a same-cycle overflow still sets it
  wire flag0_nxt = ovf0 | (flag0_r & ~(wr_misc & ~wb_dat_i[MISC_FLAG0_BIT]));
  wire flag1_nxt = ovf1 | (flag1_r & ~(wr_misc & ~wb_dat_i[MISC_FLAG1_BIT]));
  wire ien0_nxt  = wr_misc ? wb_dat_i[MISC_IEN0_BIT]  : ien0_r;
  wire ien1_nxt  = wr_misc ? wb_dat_i[MISC_IEN1_BIT]  : ien1_r;
  wire divon_nxt = wr_misc ? wb_dat_i[MISC_PFDON_BIT] : div_on_r;
  wire divsr_nxt = wr_misc ? wb_dat_i[MISC_PFDSR_BIT] : div_src_r;
  wire pin3_nxt  = wr_misc ? wb_dat_i[MISC_PIN3_BIT]  : pin3_latch_r;
  wire div_ovf   = div_src_r ? ovf1 : ovf0;
  wire div_q_nxt = div_q_r ^ div_ovf;
  wire pin_nxt   = div_on_r ? (pin3_latch_r & div_q_r) : pin3_latch_r;
  wire irq0_nxt  = flag0_r & ien0_r;
  wire irq1_nxt  = flag1_r & ien1_r;
  wire wake_nxt  = ovf0 | ovf1;

  // ----------------------------------------------------------------
  // bus and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      dat_r   <= 32'h0000_0000;
      ctrl0_r <= CTRL_RESET;
      ctrl1_r <= CTRL_RESET;
      psc_r   <= '0;
    end else begin
      ack_r   <= req & ~ack_r;
      dat_r   <= (rd & ~ack_r) ? rd_word : dat_r;
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      psc_r   <= PSC_W'(psc_r + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // flags, options and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {flag0_r, flag1_r, ien0_r, ien1_r} <= 4'h0;
      {div_on_r, div_src_r, div_q_r}     <= 3'b000;
      pin3_latch_r <= PIN3_RESET;
      pin_r        <= PIN3_RESET;
      {irq0_r, irq1_r, wake_r, pwm_r}    <= 4'h0;
    end else begin
      flag0_r   <= flag0_nxt;
      flag1_r   <= flag1_nxt;
      ien0_r    <= ien0_nxt;
      ien1_r    <= ien1_nxt;
      div_on_r     <= divon_nxt;
      div_src_r    <= divsr_nxt;
      pin3_latch_r <= pin3_nxt;
      div_q_r      <= div_q_nxt;
      pin_r     <= pin_nxt;
      irq0_r    <= irq0_nxt;
      irq1_r    <= irq1_nxt;
      wake_r    <= wake_nxt;
      pwm_r     <= tick0;
    end
  end

  assign wb_ack_o         = ack_r;
  assign wb_dat_o         = dat_r;
  assign ctr0_irq         = irq0_r;
  assign ctr1_irq         = irq1_r;
  assign wake             = wake_r;
  assign porta_pin3       = pin_r;
  assign freq_divider_out = div_q_r;
  assign pwm_clk_tick     = pwm_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wake_ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovf0 || ovf1 |=> wake)
    else $error("overflow did not wake");
  div_source_a: assert property (@(posedge clk) disable iff (!rst_n)
    div_src_r && ovf0 && !ovf1 |=> freq_divider_out == $past(freq_divider_out))
    else $error("unselected counter drove the divider");
  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ien0_r |=> !ctr0_irq)
    else $error("masked interrupt raised");
  pin_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    div_on_r && !pin3_latch_r |=> !porta_pin3)
    else $error("pin not forced low by latch");
  prescale_div_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick0 && ctrl0_r[2:0] == 3'h2 |=> (!tick0 || ctrl0_r[2:0] != 3'h2) [*3])
    else $error("prescaler divide by four wrong");
  prescale_min_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick0 && !wr_ctrl0 |=> !tick0)
    else $error("prescaler faster than half clock");
  pwm_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick0 |=> pwm_clk_tick)
    else $error("pwm tick missing");
  ctrl1_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o && hit_ctrl1 && !wb_we_i |-> wb_dat_o[2:0] == 3'b000 && !wb_dat_o[5])
    else $error("counter 1 unused bits not zero");
  div_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    div_ovf |=> freq_divider_out != $past(freq_divider_out))
    else $error("divider did not toggle");
  ack_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : dtec_top

`default_nettype wire

// *** design/dtec_pkg.sv ***
package dtec_pkg;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_UNUSED = 2'b00,
    MODE_EVENT  = 2'b01,
    MODE_TIMER  = 2'b10,
    MODE_PULSE  = 2'b11
  } dtec_mode_t;

  typedef enum logic {
    PW_WAIT = 1'b0,
    PW_MEAS = 1'b1
  } dtec_pw_t;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] CTRL0_IDX = 6'h0E;
  localparam logic [5:0] CTRL1_IDX = 6'h11;
  localparam logic [5:0] CNT0_IDX  = 6'h0C;
  localparam logic [5:0] CNT1_IDX  = 6'h0F;
  localparam logic [5:0] MISC_IDX  = 6'h0B;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_PSC_LSB  = 0;
  localparam int CTL_EDGE_BIT = 3;
  localparam int CTL_RUN_BIT  = 4;
  localparam int CTL_MODE_LSB = 6;

  // ----------------------------------------------------------------
  // misc register fields
  // ----------------------------------------------------------------
  localparam int MISC_FLAG0_BIT = 0;
  localparam int MISC_FLAG1_BIT = 1;
  localparam int MISC_IEN0_BIT  = 2;
  localparam int MISC_IEN1_BIT  = 3;
  localparam int MISC_PFDON_BIT = 4;
  localparam int MISC_PFDSR_BIT = 5;
  localparam int MISC_PIN3_BIT  = 6;
  localparam int MISC_PFDQ_BIT  = 7;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET = 8'h08;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic        PIN3_RESET = 1'b1;
  localparam int          PSC_W      = 7;

endpackage : dtec_pkg

// *** design/dtec_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

module dtec_counter
  import dtec_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // count sources
  input  wire logic               ev_in,
  input  wire logic               tick,
  // configuration
  input  wire dtec_pkg::dtec_mode_t mode,
  input  wire logic               edge_sel,
  input  wire logic               hold,
  // software access
  input  wire logic [1:0]         pre_be,
  input  wire logic [15:0]        pre_wdata,
  input  wire logic               run_wr,
  input  wire logic               run_wdata,
  // state
  output logic [15:0]             count,
  output logic                    run,
  output logic                    ovf
);
  import dtec_pkg::*;

  // ----------------------------------------------------------------
  // input synchroniser and edges
  // ----------------------------------------------------------------
  logic     s1_r, s2_r, s3_r;
  logic [15:0] count_r, preload_r, count_nxt, preload_nxt;
  logic     run_r, run_nxt;
  dtec_pw_t pw_r, pw_nxt;

  wire rise     = s2_r & ~s3_r;
  wire fall     = ~s2_r & s3_r;
  wire ev_edge  = edge_sel ? fall : rise;
  wire pw_start = edge_sel ? rise : fall;
  wire pw_stop  = edge_sel ? fall : rise;
  wire pre_wr   = |pre_be;
  wire top_val  = (count_r == CNT_MAX);
  wire pw_done  = run_r && mode == MODE_PULSE && pw_r == PW_MEAS && pw_stop;

  // hold blocks the count clock during a software read
  wire adv = run_r && !hold && (
             (mode == MODE_EVENT) ? ev_edge :
             (mode == MODE_TIMER) ? tick :
             (mode == MODE_PULSE) ? (pw_r == PW_MEAS && tick && !pw_stop) :
             1'b0);

  assign preload_nxt = {pre_be[1] ? pre_wdata[15:8] : preload_r[15:8],
                        pre_be[0] ? pre_wdata[7:0]  : preload_r[7:0]};
  assign count_nxt   = (pre_wr && !run_r) ? preload_nxt :
                       !adv ? count_r :
                       top_val ? preload_r : 16'(count_r + 16'h0001);
  // software write wins over the hardware clear
  assign run_nxt     = run_wr ? run_wdata :
                       pw_done ? 1'b0 : run_r;
  assign pw_nxt      = (!run_r || mode != MODE_PULSE || pw_done) ? PW_WAIT :
                       (pw_r == PW_WAIT && pw_start) ? PW_MEAS : pw_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {s1_r, s2_r, s3_r} <= 3'b000;
      count_r   <= CNT_RESET;
      preload_r <= CNT_RESET;
      run_r     <= 1'b0;
      pw_r      <= PW_WAIT;
    end else begin
      {s1_r, s2_r, s3_r} <= {ev_in, s1_r, s2_r};
      count_r   <= count_nxt;
      preload_r <= preload_nxt;
      run_r     <= run_nxt;
      pw_r      <= pw_nxt;
    end
  end

  assign count = count_r;
  assign run   = run_r;
  assign ovf   = adv && top_val;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_stopped_a: assert property (@(posedge clk) disable iff (!rst_n)
    !run_r && !pre_wr |=> count_r == $past(count_r))
    else $error("count moved while disabled");
  pw_autoclear_a: assert property (@(posedge clk) disable iff (!rst_n)
    pw_done && !run_wr |=> !run_r)
    else $error("run not cleared after pulse measurement");
  run_sw_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode != MODE_PULSE && !run_wr |=> run_r == $past(run_r))
    else $error("run changed without a write");
  load_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    pre_be == 2'b11 && !run_r |=> count_r == $past(pre_wdata))
    else $error("preload write did not load count");
  load_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    pre_be == 2'b11 && run_r |=> preload_r == $past(pre_wdata)
      && ($past(adv) || count_r == $past(count_r)))
    else $error("running counter disturbed by preload write");
  read_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    hold && !(pre_wr && !run_r) |=> count_r == $past(count_r))
    else $error("count moved during a read");
  wrap_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    adv && top_val |-> ovf ##1 count_r == $past(preload_r))
    else $error("overflow did not reload");
  event_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MODE_EVENT && run_r && !hold && ev_edge && !top_val
      |=> count_r == 16'($past(count_r) + 16'h0001))
    else $error("event edge not counted");
  timer_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == MODE_TIMER && run_r && !hold && !tick |=> count_r == $past(count_r))
    else $error("timer advanced without a tick");
  pw_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !run_r && !run_wr |=> !run_r && pw_r == PW_WAIT)
    else $error("measurement restarted without software");

endmodule : dtec_counter

`default_nettype wire

// *** verif/dtec_edge_src.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// external pulse source on an event input
// ----------------------------------------------------------------
module dtec_edge_src (
  // clock
  input  wire logic       clk,
  // command: number of toggles and spacing
  input  wire logic       go,
  input  wire logic [3:0] ntog,
  input  wire logic [7:0] gap,
  // line and status
  output logic            line,
  output logic            busy
);
  logic [3:0] left_r;
  logic [7:0] wait_r;

  initial begin
    line = 1'b0;
    busy = 1'b0;
    left_r = 4'h0;
    wait_r = 8'h00;
  end

  // levels held gap+1 clocks, far beyond the input sampling depth
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left_r <= ntog;
      wait_r <= gap;
    end else if (busy) begin
      if (wait_r != 8'h00) begin
        wait_r <= wait_r - 8'h01;
      end else if (left_r != 4'h0) begin
        line <= ~line;
        left_r <= left_r - 4'h1;
        wait_r <= gap;
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule : dtec_edge_src

`default_nettype wire

// *** verif/test_dual_timer_event_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module test_dual_timer_event_counter;
  import dtec_pkg::*;
  // ----------------------------------------------------------------
  // addresses and signals
  // ----------------------------------------------------------------
  localparam logic [7:0] A_T0 = {CTRL0_IDX, 2'b00};
  localparam logic [7:0] A_T1 = {CTRL1_IDX, 2'b00};
  localparam logic [7:0] A_C0 = {CNT0_IDX, 2'b00};
  localparam logic [7:0] A_C1 = {CNT1_IDX, 2'b00};
  localparam logic [7:0] A_MS = {MISC_IDX, 2'b00};
  logic        clk, rst_n, cyc, stb, we, go, wake_seen;
  logic [7:0]  adr, gap;
  logic [3:0]  ntog, sel;
  logic [31:0] wdat, rng;
  logic [63:0] q;
  wire logic [31:0] rdat;
  wire logic   ack, irq0, irq1, wake, pin3, fdo, ptick, ev1, busy;
  int          miscompares, checks_done, n;
  logic [63:0] expq[$];

  dtec_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ctr0_event_in(ev1), .ctr1_event_in(ev1), .ctr0_irq(irq0), .ctr1_irq(irq1),
    .wake(wake), .porta_pin3(pin3), .freq_divider_out(fdo), .pwm_clk_tick(ptick));
  dtec_edge_src i_src (.clk(clk), .go(go), .ntog(ntog), .gap(gap), .line(ev1), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] e = 0, input logic [31:0] m = 32'hffff_ffff);
    int k;
    if (!w) expq.push_back({e, m});
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
    if (k >= 50) miscompares++;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  task automatic src(input logic [3:0] t, input logic [7:0] g);
    int k;
    @(posedge clk);
    go <= 1'b1; ntog <= t; gap <= g;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin @(posedge clk); k++; end while (busy !== 1'b0 && k < 400);
    if (k >= 400) miscompares++;
    repeat (8) @(posedge clk);
  endtask : src

  task automatic wait_tick(output int k);
    k = 0;
    do begin @(posedge clk); k++; end while (ptick !== 1'b1 && k < 300);
  endtask : wait_tick

  task report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // read data checked against the oldest note at each read ack
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) miscompares++;
      else begin q = expq.pop_front(); `CHK("wb_dat_o", q[63:32] & q[31:0], rdat & q[31:0]) end
    end
    if (wake === 1'b1) wake_seen <= 1'b1;
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; sel = 4'hf; go = 0; ntog = 0; gap = 0;
    wake_seen = 0; rng = 32'hcf97_f633; rst_n = 0; miscompares = 0; checks_done = 0;
    repeat (12) @(posedge clk);
    `CHK("porta_pin3", 1'b1, pin3)
    rst_n <= 1'b1;
    wb(0, A_T0, 0, 32'h08);
    wb(0, A_MS, 0, 32'h40);
    wb(0, 8'h04, 0, 0);
    wb(1, A_T1, 32'h2f);
    wb(0, A_T1, 0, 32'h08);
    rng = xs(rng);
    wb(1, A_C1, rng);
    wb(0, A_C1, 0, {16'h0000, rng[15:0]});
    for (int i = 0; i < 8; i++) begin
      wb(1, A_T0, i);
      // the first tick seen may still come from the previous code
      repeat (3) wait_tick(n);
      `CHK("tick period", 1 << ((i == 0) ? 1 : i), n)
    end
    // falling edges with edge bit 1, rising with 0; odd toggle counts tell them apart
    for (int j = 0; j < 2; j++) begin
      for (int c = 0; c < 2; c++) begin
        wb(1, c ? A_T1 : A_T0, 32'h48 - j * 8);
        wb(1, c ? A_C1 : A_C0, 0);
        wb(1, c ? A_T1 : A_T0, 32'h58 - j * 8);
      end
      src(j ? 3 : 5, 5);
      for (int c = 0; c < 2; c++) begin
        wb(1, c ? A_T1 : A_T0, 32'h48 - j * 8);
        wb(0, c ? A_C1 : A_C0, 0, j ? 1 : 2);
      end
    end
    wb(1, A_T1, 32'hc8);
    wb(1, A_C1, 0);
    wb(1, A_T1, 32'hd8);
    src(3, 21);
    wb(0, A_T1, 0, 32'hc8);
    wb(0, A_C1, 0, 32'h14, 32'hfffc);
    src(2, 21);
    wb(0, A_C1, 0, 32'h14, 32'hfffc);
    wb(1, A_T0, 32'h87);
    wb(1, A_MS, 32'h54);
    wb(1, A_C0, 32'hfffe);
    wb(1, A_T0, 32'h97);
    wb(1, A_C0, 32'h1234);
    wb(0, A_C0, 0, 32'hfffe, 32'hfffe);
    n = 0;
    do begin @(posedge clk); n++; end while (irq0 !== 1'b1 && n < 600);
    if (n >= 600) miscompares++;
    wb(0, A_T0, 0, 32'h97);
    wb(1, A_T0, 32'h87);
    wb(0, A_C0, 0, 32'h1234);
    wb(0, A_MS, 0, 32'hd5);
    `CHK("freq_divider_out", 1'b1, fdo)
    `CHK("porta_pin3", 1'b1, pin3)
    `CHK("wake", 1'b1, wake_seen)
    wb(1, A_MS, 32'h11);
    repeat (3) @(posedge clk);
    `CHK("ctr0_irq", 1'b0, irq0)
    `CHK("porta_pin3", 1'b0, pin3)
    wb(0, A_MS, 0, 32'h91);
    // counter 1 as divider source: one wrap toggles the divider back to 0
    wb(1, A_MS, 32'h38);
    wb(1, A_C1, 32'hffe0);
    wb(1, A_T1, 32'h98);
    wb(1, A_C1, 0);
    repeat (40) @(posedge clk);
    wb(1, A_T1, 32'h88);
    wb(0, A_MS, 0, 32'h3a);
    `CHK("freq_divider_out", 1'b0, fdo)
    `CHK("ctr1_irq", 1'b1, irq1)
    report_and_stop();
  end
endmodule : test_dual_timer_event_counter

`default_nettype wire
